// File: include/hdpr_pkg.sv
// Purpose: constants shared by the haptic drive parameter register bank
// Assumes: 50 MHz system clock, 7-bit serial slave address
// Notes: register offsets are byte addresses on the two-wire serial bus
`default_nettype none
package hdpr_pkg;
   // ===========================================================
   // clock and timing
   localparam int CLK_HZ = 50_000_000;
   localparam int BUS_TIMEOUT_MS = 35;
   localparam int BUS_TIMEOUT_CYCLES = BUS_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int TIMEOUT_CNT_W = 21;

   // ===========================================================
   // serial slave address (arbitrary value)
   localparam logic [6:0] DEV_ADDR = 7'h4A;

   // ===========================================================
   // register offsets
   localparam logic [7:0] SERIAL_PORT_CONFIG_OFS = 8'h08;
   localparam logic [7:0] RESONANCE_PERIOD_HIGH_OFS = 8'h0A;
   localparam logic [7:0] RESONANCE_PERIOD_LOW_OFS = 8'h0B;
   localparam logic [7:0] NOMINAL_VOLTAGE_RATING_OFS = 8'h0C;
   localparam logic [7:0] ABSOLUTE_VOLTAGE_RATING_OFS = 8'h0D;
   localparam logic [7:0] CURRENT_RATING_OFS = 8'h0E;
   localparam logic [7:0] DRIVE_CONVERSION_HIGH_OFS = 8'h0F;

   // ===========================================================
   // field positions and widths
   localparam int WR_MODE_BIT = 7;
   localparam int BUS_TIMEOUT_EN_BIT = 6;
   localparam int PERIOD_LOW_W = 7;
   localparam int PERIOD_W = 15;
   localparam int MAX_CURRENT_W = 5;

   // ===========================================================
   // reset values
   localparam logic WR_MODE_RST = 1'h0;
   localparam logic BUS_TIMEOUT_EN_RST = 1'h1;
   localparam logic [7:0] PERIOD_HIGH_RST = 8'h21;
   localparam logic [6:0] PERIOD_LOW_RST = 7'h4F;
   localparam logic [7:0] NOMINAL_RST = 8'h5A;
   localparam logic [7:0] ABSOLUTE_RST = 8'h78;
   localparam logic [4:0] MAX_CURRENT_RST = 5'h17;
   localparam logic [7:0] CONVERSION_HIGH_RST = 8'h01;

   // ===========================================================
   // write framing styles
   localparam logic WR_MODE_AUTO_INC = 1'h0;
   localparam logic WR_MODE_REPEAT = 1'h1;

   // ===========================================================
   // serial slave states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DEVADDR,
      ST_REGADDR,
      ST_WDATA,
      ST_RDATA
   } hdpr_state_type;
endpackage
`default_nettype wire

// File: rtl/hdpr_regs.sv
// Purpose: parameter register bank of a haptic driver, reached over a serial slave
// Assumes: scl and sda inputs already synchronous to i_clk; sda is open drain
// Notes: reads auto-increment; unmapped offsets read 0x00 and ignore writes
`timescale 1ns/1ps
`default_nettype none

// Operation
// - write-style bit 0: address then data run; 1: address before every data byte
// - with timeout enabled, no scl falling edge for 35 ms resets the slave
// - resonance period is 15 bits; high register holds bits 14 to 7
// - low register holds bits 6 to 0; period is 128 times high plus low
// - period registers reset to 0x21 high and 0x4F low, a 174 Hz resonance
// - nominal rating resets 0x5A; full scale of unsigned data with acceleration on
// - absolute rating resets 0x78; overdrive clamped to it with acceleration on
// - with acceleration off, absolute rating sets unsigned full scale instead
// - max current code is 5 bits, resets to 0x17
// - conversion factor high byte resets to 0x01, upper half of 16 bits
module hdpr_regs
   import hdpr_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = BUS_TIMEOUT_CYCLES
)
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // serial bus
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_out,
   output logic o_sda_oe,
   // drive loop side
   input wire logic i_accel_en,
   output logic [PERIOD_W-1:0] o_resonance_period,
   output logic [7:0] o_full_scale,
   output logic [7:0] o_overdrive_limit,
   output logic o_overdrive_clamp_en,
   output logic [MAX_CURRENT_W-1:0] o_max_current_code,
   output logic [7:0] o_drive_conversion_high,
   output logic o_wr_mode,
   output logic o_bus_timeout_en
);

   // ===========================================================
   // state
   typedef struct packed {
      hdpr_state_type st;
      logic scl_q;
      logic sda_q;
      logic [3:0] bitcnt;
      logic [7:0] shift;
      logic [7:0] ptr;
      logic ack_phase;
      logic mack_phase;
      logic nack;
      logic sda_oe;
      logic [TIMEOUT_CNT_W-1:0] to_cnt;
      logic wr_mode;
      logic bus_timeout_en;
      logic [7:0] period_high;
      logic [PERIOD_LOW_W-1:0] period_low;
      logic [7:0] nominal;
      logic [7:0] absolute;
      logic [MAX_CURRENT_W-1:0] max_current_code;
      logic [7:0] conversion_high;
      logic [7:0] full_scale;
      logic clamp_en;
   } hdpr_regs_type;

   hdpr_regs_type r_reg;
   hdpr_regs_type r_next;

   localparam logic [TIMEOUT_CNT_W-1:0] TO_LAST = TIMEOUT_CNT_W'(TIMEOUT_CYCLES - 1);

   // ===========================================================
   // register read mux
   function automatic logic [7:0] rd_byte(input hdpr_regs_type s, input logic [7:0] a);
      logic [7:0] d;
      d = 8'h00;
      unique case (a)
         SERIAL_PORT_CONFIG_OFS:
         begin
            d[WR_MODE_BIT] = s.wr_mode;
            d[BUS_TIMEOUT_EN_BIT] = s.bus_timeout_en;
         end
         RESONANCE_PERIOD_HIGH_OFS: d = s.period_high;
         RESONANCE_PERIOD_LOW_OFS: d = {1'b0, s.period_low};
         NOMINAL_VOLTAGE_RATING_OFS: d = s.nominal;
         ABSOLUTE_VOLTAGE_RATING_OFS: d = s.absolute;
         CURRENT_RATING_OFS: d = {3'h0, s.max_current_code};
         DRIVE_CONVERSION_HIGH_OFS: d = s.conversion_high;
         default: d = 8'h00;
      endcase
      return d;
   endfunction

   // ===========================================================
   // next state
   always_comb
   begin
      logic scl_rise;
      logic scl_fall;
      logic start_c;
      logic stop_c;
      logic [7:0] rd;
      r_next = r_reg;
      scl_rise = i_scl & ~r_reg.scl_q;
      scl_fall = ~i_scl & r_reg.scl_q;
      start_c = i_scl & r_reg.scl_q & r_reg.sda_q & ~i_sda;
      stop_c = i_scl & r_reg.scl_q & ~r_reg.sda_q & i_sda;
      rd = rd_byte(r_reg, r_reg.ptr);
      r_next.scl_q = i_scl;
      r_next.sda_q = i_sda;

      // bus stall watchdog, counts only inside a transfer
      if (r_reg.st == ST_IDLE || scl_fall)
         r_next.to_cnt = '0;
      else
         r_next.to_cnt = r_reg.to_cnt + 1'b1;

      if (start_c)
      begin
         // start or repeated start, pointer kept
         r_next.st = ST_DEVADDR;
         r_next.bitcnt = 4'h0;
         r_next.ack_phase = 1'b0;
         r_next.mack_phase = 1'b0;
         r_next.sda_oe = 1'b0;
      end
      else if (stop_c)
      begin
         r_next.st = ST_IDLE;
         r_next.sda_oe = 1'b0;
      end
      else if (r_reg.bus_timeout_en && r_reg.st != ST_IDLE && r_reg.to_cnt == TO_LAST)
      begin
         // abandon the transfer, registers untouched
         r_next.st = ST_IDLE;
         r_next.sda_oe = 1'b0;
         r_next.ack_phase = 1'b0;
         r_next.mack_phase = 1'b0;
         r_next.to_cnt = '0;
      end
      else if (scl_rise && r_reg.st != ST_IDLE)
      begin
         // sample data or master acknowledge
         if (r_reg.mack_phase)
            r_next.nack = i_sda;
         else if (!r_reg.ack_phase && r_reg.bitcnt < 4'h8)
         begin
            if (r_reg.st != ST_RDATA)
               r_next.shift = {r_reg.shift[6:0], i_sda};
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
         end
      end
      else if (scl_fall && r_reg.st != ST_IDLE)
      begin
         if (r_reg.ack_phase || (r_reg.mack_phase && !r_reg.nack))
         begin
            // end of acknowledge slot, start next byte
            r_next.ack_phase = 1'b0;
            r_next.mack_phase = 1'b0;
            r_next.bitcnt = 4'h0;
            r_next.sda_oe = 1'b0;
            if (r_reg.st == ST_RDATA)
            begin
               r_next.shift = rd;
               r_next.ptr = r_reg.ptr + 8'h01;
               r_next.sda_oe = ~rd[7];
            end
         end
         else if (r_reg.mack_phase)
         begin
            // master refused more data
            r_next.mack_phase = 1'b0;
            r_next.st = ST_IDLE;
         end
         else if (r_reg.bitcnt == 4'h8)
         begin
            r_next.ack_phase = 1'b1;
            r_next.sda_oe = 1'b1;
            unique case (r_reg.st)
               ST_DEVADDR:
               begin
                  if (r_reg.shift[7:1] != DEV_ADDR)
                  begin
                     r_next.st = ST_IDLE;
                     r_next.ack_phase = 1'b0;
                     r_next.sda_oe = 1'b0;
                  end
                  else if (r_reg.shift[0])
                     r_next.st = ST_RDATA;
                  else
                     r_next.st = ST_REGADDR;
               end
               ST_REGADDR:
               begin
                  r_next.ptr = r_reg.shift;
                  r_next.st = ST_WDATA;
               end
               ST_WDATA:
               begin
                  // store the byte into the addressed register
                  unique case (r_reg.ptr)
                     SERIAL_PORT_CONFIG_OFS:
                     begin
                        r_next.wr_mode = r_reg.shift[WR_MODE_BIT];
                        r_next.bus_timeout_en = r_reg.shift[BUS_TIMEOUT_EN_BIT];
                     end
                     RESONANCE_PERIOD_HIGH_OFS: r_next.period_high = r_reg.shift;
                     RESONANCE_PERIOD_LOW_OFS:
                        r_next.period_low = r_reg.shift[PERIOD_LOW_W-1:0];
                     NOMINAL_VOLTAGE_RATING_OFS: r_next.nominal = r_reg.shift;
                     ABSOLUTE_VOLTAGE_RATING_OFS: r_next.absolute = r_reg.shift;
                     CURRENT_RATING_OFS:
                        r_next.max_current_code = r_reg.shift[MAX_CURRENT_W-1:0];
                     DRIVE_CONVERSION_HIGH_OFS: r_next.conversion_high = r_reg.shift;
                     default: r_next.ptr = r_reg.ptr;
                  endcase
                  // framing of the following byte
                  if (r_reg.wr_mode == WR_MODE_REPEAT)
                     r_next.st = ST_REGADDR;
                  else
                     r_next.ptr = r_reg.ptr + 8'h01;
               end
               ST_RDATA:
               begin
                  // release sda for the master acknowledge
                  r_next.ack_phase = 1'b0;
                  r_next.sda_oe = 1'b0;
                  r_next.mack_phase = 1'b1;
                  r_next.nack = 1'b0;
               end
               default: r_next.st = ST_IDLE;
            endcase
         end
         else if (r_reg.st == ST_RDATA && r_reg.bitcnt != 4'h0)
         begin
            // next read bit out
            r_next.shift = {r_reg.shift[6:0], 1'b0};
            r_next.sda_oe = ~r_reg.shift[6];
         end
      end

      // drive loop values, selected by acceleration
      r_next.full_scale = i_accel_en ? r_reg.nominal : r_reg.absolute;
      r_next.clamp_en = i_accel_en;
   end

   // ===========================================================
   // state register
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         r_reg <= '0;
         r_reg.st <= ST_IDLE;
         r_reg.scl_q <= 1'b1;
         r_reg.sda_q <= 1'b1;
         r_reg.wr_mode <= WR_MODE_RST;
         r_reg.bus_timeout_en <= BUS_TIMEOUT_EN_RST;
         r_reg.period_high <= PERIOD_HIGH_RST;
         r_reg.period_low <= PERIOD_LOW_RST;
         r_reg.nominal <= NOMINAL_RST;
         r_reg.absolute <= ABSOLUTE_RST;
         r_reg.max_current_code <= MAX_CURRENT_RST;
         r_reg.conversion_high <= CONVERSION_HIGH_RST;
         r_reg.full_scale <= ABSOLUTE_RST;
      end
      else
         r_reg <= r_next;
   end

   // ===========================================================
   // outputs
   assign o_sda_out = 1'b0; // open drain, only pulls low
   assign o_sda_oe = r_reg.sda_oe;
   assign o_resonance_period = {r_reg.period_high, r_reg.period_low};
   assign o_full_scale = r_reg.full_scale;
   assign o_overdrive_limit = r_reg.absolute;
   assign o_overdrive_clamp_en = r_reg.clamp_en;
   assign o_max_current_code = r_reg.max_current_code;
   assign o_drive_conversion_high = r_reg.conversion_high;
   assign o_wr_mode = r_reg.wr_mode;
   assign o_bus_timeout_en = r_reg.bus_timeout_en;

endmodule

`default_nettype wire

// File: test/hdpr_chk.sv
// Purpose: assertions on the ports of the haptic parameter register bank
// Assumes: scl holds each level for at least 3 clocks
// Notes: bound to hdpr_regs after the module
`timescale 1ns/1ps
`default_nettype none
module hdpr_chk
   import hdpr_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = BUS_TIMEOUT_CYCLES
)
(
   // clock, reset and serial bus
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic o_sda_out,
   input wire logic o_sda_oe,
   // drive loop side
   input wire logic i_accel_en,
   input wire logic o_overdrive_clamp_en,
   input wire logic o_wr_mode,
   input wire logic o_bus_timeout_en,
   input wire logic [PERIOD_W-1:0] o_resonance_period,
   input wire logic [7:0] o_full_scale,
   input wire logic [7:0] o_overdrive_limit,
   input wire logic [7:0] o_drive_conversion_high,
   input wire logic [MAX_CURRENT_W-1:0] o_max_current_code
);
   // ===========================================================
   // cycles since the last scl fall, saturating
   logic [21:0] fall_cnt_reg;
   always_ff @(posedge i_clk or negedge i_nrst)
      if (!i_nrst)
         fall_cnt_reg <= 22'h0;
      else if ($fell(i_scl))
         fall_cnt_reg <= 22'h0;
      else if (fall_cnt_reg != 22'h3FFFFF)
         fall_cnt_reg <= fall_cnt_reg + 22'h1;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // ===========================================================
   // assertions
   reset_period_a: assert property ($rose(i_nrst) |-> o_resonance_period == 15'h10CF)
      else $error("period not at reset value");
   reset_rating_a: assert property ($rose(i_nrst) |-> o_overdrive_limit == 8'h78
      && o_max_current_code == 5'h17 && o_drive_conversion_high == 8'h01)
      else $error("ratings not at reset value");
   reset_config_a: assert property ($rose(i_nrst) |-> !o_wr_mode && o_bus_timeout_en)
      else $error("config not at reset value");
   full_scale_a: assert property (!$past(i_accel_en) |-> o_full_scale == $past(o_overdrive_limit))
      else $error("full scale not from absolute rating");
   clamp_follow_a: assert property (o_overdrive_clamp_en == $past(i_accel_en))
      else $error("clamp enable does not follow acceleration");
   oe_rise_a: assert property ($rose(o_sda_oe) |-> !i_scl && !$past(i_scl))
      else $error("sda driven outside scl low");
   oe_hold_a: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe))
      else $error("sda drive changed while scl high");
   timeout_rel_a: assert property (o_bus_timeout_en && fall_cnt_reg > 22'(TIMEOUT_CYCLES + 2)
      |-> !o_sda_oe)
      else $error("sda held after bus timeout");
   period_write_a: assert property ($changed(o_resonance_period) |-> !i_scl && !$past(i_scl))
      else $error("period changed outside scl low");
   // main scenarios
   cover property ($rose(o_sda_oe));
   cover property ($rose(o_wr_mode));
   cover property (o_bus_timeout_en && fall_cnt_reg > 22'(TIMEOUT_CYCLES + 2));
endmodule
bind hdpr_regs hdpr_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_hdpr_chk (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out),
   .o_sda_oe(o_sda_oe), .i_accel_en(i_accel_en), .o_overdrive_clamp_en(o_overdrive_clamp_en),
   .o_wr_mode(o_wr_mode), .o_bus_timeout_en(o_bus_timeout_en),
   .o_resonance_period(o_resonance_period), .o_full_scale(o_full_scale),
   .o_overdrive_limit(o_overdrive_limit), .o_drive_conversion_high(o_drive_conversion_high),
   .o_max_current_code(o_max_current_code));
`default_nettype wire

// File: test/hdpr_host.sv
// Purpose: two-wire bus host model for the register bank
// Assumes: sda pulled up outside, so a released line reads high
// Notes: each scl phase lasts 4 clocks; scl stands high between frames
`timescale 1ns/1ps
`default_nettype none
module hdpr_host
(
   // clock and resolved data line
   input wire logic i_clk,
   input wire logic i_sda,
   // bus drive
   output logic o_scl,
   output logic o_sda_low
);
   // ===========================================================
   // bus idle at time zero
   initial
   begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   // wait n clocks, then change just after the edge
   task automatic tick(input int n = 4);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // start or repeated start
   task automatic start;
      o_sda_low = 1'b0;
      tick();
      o_scl = 1'b1;
      tick();
      o_sda_low = 1'b1;
      tick();
      o_scl = 1'b0;
   endtask
   // stop, leaving the bus idle
   task automatic stop;
      o_sda_low = 1'b1;
      tick();
      o_scl = 1'b1;
      tick();
      o_sda_low = 1'b0;
      tick();
   endtask
   // eight bits msb first, then the ack bit; a released bit reads the device
   task automatic byte_io(input logic [7:0] d, input logic nack, output logic [7:0] q,
                          output logic ak);
      logic [8:0] sh;
      sh = {d, nack};
      for (int i = 8; i >= 0; i--)
      begin
         o_sda_low = !sh[i];
         tick();
         o_scl = 1'b1;
         tick();
         sh[i] = i_sda;
         o_scl = 1'b0;
      end
      q = sh[8:1];
      ak = sh[0];
   endtask
endmodule
`default_nettype wire

// File: test/haptic_drive_param_regs_tb.sv
// Purpose: self-checking bench for the haptic parameter register bank
// Assumes: bus timeout shortened to 200 clocks
// Notes: registers reached only over the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module haptic_drive_param_regs_tb
   import hdpr_pkg::*;
;
   localparam int unsigned TO_CYC = 200;
   localparam logic [7:0] WR_ADDR = {DEV_ADDR, 1'b0};
   localparam logic [7:0] RD_OFS [8] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F};
   localparam logic [7:0] RST_V [8] = '{8'h40, 8'h00, 8'h21, 8'h4F, 8'h5A, 8'h78, 8'h17, 8'h01};
   localparam logic [7:0] BURST [6] = '{8'h12, 8'hB5, 8'h33, 8'h44, 8'hFF, 8'h9C};
   localparam logic [7:0] BACK [6] = '{8'h12, 8'h35, 8'h33, 8'h44, 8'h1F, 8'h9C};
   localparam logic [7:0] REP [4] = '{8'h0C, 8'h11, 8'h0D, 8'h22};
   logic clk, nrst, accel, scl, host_low, sda, sda_out, sda_oe, clamp, wr_mode, to_en, ak;
   logic [PERIOD_W-1:0] period;
   logic [MAX_CURRENT_W-1:0] icode;
   logic [7:0] full, limit, conv, q;
   int miscompares = 0;
   int num_checks = 0;
   // open-drain data line with pull-up
   assign sda = ~(host_low | sda_oe);
   hdpr_regs #(.TIMEOUT_CYCLES(TO_CYC)) u_hdpr_regs (
      .i_clk(clk), .i_nrst(nrst), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
      .o_sda_oe(sda_oe), .i_accel_en(accel), .o_resonance_period(period),
      .o_full_scale(full), .o_overdrive_limit(limit), .o_overdrive_clamp_en(clamp),
      .o_max_current_code(icode), .o_drive_conversion_high(conv), .o_wr_mode(wr_mode),
      .o_bus_timeout_en(to_en));
   hdpr_host u_hdpr_host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
   // ===========================================================
   // compare, report and bus tasks
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic send(input logic [7:0] d);
      u_hdpr_host.byte_io(d, 1'b1, q, ak);
      chk_val({15'h0000, ak}, 16'h0000);
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      u_hdpr_host.start();
      send(WR_ADDR);
      send(a);
      send(d);
      u_hdpr_host.stop();
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
      u_hdpr_host.start();
      send(WR_ADDR);
      send(a);
      u_hdpr_host.start();
      send({DEV_ADDR, 1'b1});
      u_hdpr_host.byte_io(8'hFF, 1'b1, q, ak);
      u_hdpr_host.stop();
      chk_val({8'h00, q}, {8'h00, exp});
   endtask
   // ===========================================================
   // clock and watchdog
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial
   begin
      // the tests need about 9,000 clocks; give them roughly twice that
      #400000;
      miscompares++;
      final_report();
   end
   // ===========================================================
   // tests
   initial
   begin
      nrst = 1'b0;
      accel = 1'b0;
      repeat (2) @(posedge clk);
      #1 nrst = 1'b1;
      u_hdpr_host.tick(2);
      // reset values; offset 0x09 is unmapped and reads zero
      for (int i = 0; i < 8; i++)
         reg_rd(RD_OFS[i], RST_V[i]);
      chk_val(16'(period), 16'h10CF);
      chk_val(16'(sda_out), 16'h0000);
      $display("test reset done");
      // auto-increment burst across every parameter byte from 0x0A to 0x0F
      u_hdpr_host.start();
      send(WR_ADDR);
      send(8'h0A);
      foreach (BURST[i])
         send(BURST[i]);
      u_hdpr_host.stop();
      for (int i = 0; i < 6; i++)
         reg_rd(RD_OFS[i + 2], BACK[i]);
      chk_val(16'(period), 16'h0935);
      chk_val({conv, 3'h0, icode}, 16'h9C1F);
      $display("test burst done");
      // full-scale source follows acceleration
      accel = 1'b1;
      u_hdpr_host.tick(2);
      chk_val({full, limit}, 16'h3344);
      chk_val(16'(clamp), 16'h0001);
      accel = 1'b0;
      u_hdpr_host.tick(2);
      chk_val({full, 7'h00, clamp}, 16'h4400);
      $display("test full scale done");
      // repeat framing: register address before every data byte
      reg_wr(SERIAL_PORT_CONFIG_OFS, 8'hC0);
      chk_val({15'h0000, wr_mode}, 16'h0001);
      u_hdpr_host.start();
      foreach (REP[i])
         send(i == 0 ? WR_ADDR : REP[i - 1]);
      send(REP[3]);
      u_hdpr_host.stop();
      reg_rd(8'h0C, 8'h11);
      reg_rd(8'h0D, 8'h22);
      reg_rd(8'h08, 8'hC0);
      $display("test repeat done");
      // stall mid-write with timeout on, then off
      for (int en = 1; en >= 0; en--)
      begin
         reg_wr(SERIAL_PORT_CONFIG_OFS, {1'b0, en[0], 6'h00});
         chk_val({15'h0000, to_en}, 16'(en));
         u_hdpr_host.start();
         send(WR_ADDR);
         send(8'h0C);
         u_hdpr_host.tick(TO_CYC + 50);
         u_hdpr_host.byte_io(8'h77, 1'b1, q, ak);
         u_hdpr_host.stop();
         chk_val({15'h0000, ak}, 16'(en));
         reg_rd(8'h0C, en[0] ? 8'h11 : 8'h77);
      end
      $display("test timeout done");
      final_report();
   end
endmodule
`default_nettype wire
